/* bench/cmd_clk_src.sv */
// free-running source for the two selectable input clocks
`timescale 1ns/1ps
module cmd_clk_src #(parameter int HALF_A = 4, parameter int HALF_B = 6) (
  input wire logic pclk, // sampling clock
  output logic primary_clock_in, // first clock pin
  output logic secondary_clock_in // second clock pin
);
  int cnt_a = 0;
  int cnt_b = 0;
  initial primary_clock_in = 1'b0;
  initial secondary_clock_in = 1'b0;
  // whole pclk levels, at least two, so the pin synchronisers never miss an edge
  always @(posedge pclk)
  begin
    cnt_a <= (cnt_a == HALF_A - 1) ? 0 : cnt_a + 1;
    cnt_b <= (cnt_b == HALF_B - 1) ? 0 : cnt_b + 1;
    if (cnt_a == HALF_A - 1)
      primary_clock_in <= ~primary_clock_in;
    if (cnt_b == HALF_B - 1)
      secondary_clock_in <= ~secondary_clock_in;
  end
endmodule

/* bench/tb.sv */
// self-checking bench for the clock mux, divider chain and fan-out
`timescale 1ns/1ps
module tb;
  logic pclk, presetn, psel, penable, pwrite, master_clear_n, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic primary_clock_in, secondary_clock_in;
  logic [1:0] q1, q2, q3, q4;
  logic [7:0] held;
  logic [3:0] q0;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  int p;
  time t;
  logic [1:0] row_cfg [4] = '{2'h0, 2'h2, 2'h1, 2'h3}; // bit0 clock choice, bit1 ratio
  int row_p1 [4] = '{8, 16, 12, 24}; // expected first bank period in pclk
  assign q0 = {q4[0], q3[0], q2[0], q1[0]};
  cmd_clk_src src (.pclk(pclk), .primary_clock_in(primary_clock_in),
    .secondary_clock_in(secondary_clock_in));
  cmd_clock_fanout uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .primary_clock_in(primary_clock_in),
    .secondary_clock_in(secondary_clock_in), .master_clear_n(master_clear_n),
    .first_bank_outputs(q1), .second_bank_outputs(q2), .third_bank_outputs(q3),
    .fourth_bank_outputs(q4));
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one apb transfer; waits on pready, takes data at that same edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rise(input int b);
    case (b)
      0: @(posedge q1[0]);
      1: @(posedge q2[0]);
      2: @(posedge q3[0]);
      default: @(posedge q4[0]);
    endcase
  endtask
  task automatic period(input int b);
    rise(b);
    t = $time;
    rise(b);
    p = int'(($time - t) / 8);
  endtask
  // timeout guard and the two copies of every bank compared each cycle
  always @(posedge pclk)
  begin
    cycles++;
    if (presetn)
      chk({q4[1], q3[1], q2[1], q1[1]}, q0);
    if (cycles == 10000)
    begin
      failures++;
      close_out();
    end
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    master_clear_n = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, cmd_pkg::ADDR_CTRL, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk({e, r}, {1'b1, 32'h0});
    $display("end of reset test");
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, cmd_pkg::ADDR_CTRL, {30'h0, row_cfg[i]});
      repeat (200) @(posedge pclk);
      period(0);
      chk(p, row_p1[i]);
      for (int b = 1; b < 4; b++)
      begin
        period(b);
        chk(p, (row_p1[i] >> row_cfg[i][1]) << b);
      end
      rise(3);
      #1;
      chk(q0, 4'hf);
    end
    $display("end of ratio table");
    apb(1'b1, cmd_pkg::ADDR_CTRL, 32'h4);
    repeat (16) @(posedge pclk);
    held = {q1, q2, q3, q4};
    apb(1'b0, cmd_pkg::ADDR_STAT, 32'h0);
    chk(r[cmd_pkg::STAT_FROZEN_BIT], 1'b1);
    repeat (60) @(posedge pclk);
    chk({q1, q2, q3, q4}, held);
    apb(1'b1, cmd_pkg::ADDR_CTRL, 32'h0);
    period(3);
    chk(p, 64);
    $display("end of freeze test");
    @(posedge pclk);
    master_clear_n <= 1'b0;
    #1;
    chk(q0, 4'h0);
    repeat (30) @(posedge pclk);
    chk({q1, q2, q3, q4}, 8'h00);
    master_clear_n <= 1'b1;
    t = $time;
    rise(3);
    #1;
    chk({q0, ($time - t) < 160}, 5'h1f);
    $display("end of clear test");
    close_out();
  end
endmodule

/* common/cmd_pkg.sv */
// constants shared by the clock mux / divider / fan-out block
package cmd_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the apb bus)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_W = 3;
  localparam int unsigned CTRL_CLK_CHOICE_BIT = 0;
  localparam int unsigned CTRL_RATIO_BIT = 1;
  localparam int unsigned CTRL_FREEZE_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // ----------------------------------------------------------------
  // status register fields
  // ----------------------------------------------------------------
  localparam int unsigned STAT_FROZEN_BIT = 0;
  localparam int unsigned STAT_ARMED_BIT = 1;
  localparam int unsigned STAT_Q1_BIT = 2;
  localparam int unsigned STAT_CNT_LSB = 3;

  // ----------------------------------------------------------------
  // divider chain
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W = 3;
  localparam logic [2:0] CNT_RESET = 3'h0;
  localparam logic [2:0] CNT_STEP = 3'h1;
  localparam int unsigned NUM_COPIES = 2;

endpackage

/* hdl/cmd_clock_fanout.sv */
// clock multiplexer, synchronous divider chain and two-copy fan-out with apb control
//
// Operation
// - exactly one of the two input clocks feeds every divider stage
// - four stages give the selected clock divided by one, two, four, eight
// - the first bank divides by one or by two, as configured
// - every stage output drives two identical copies with identical phase
// - all stages step on the same selected clock edge, common edges aligned
// - the freeze request is captured on the falling edge of the selected clock
// - freezing and unfreezing only take effect while the internal clock is low
// - after a freeze request, stepping stops from the next falling edge
// - while frozen every divider flop keeps its state
// - after the request drops, the next falling edge resumes counting from the held state
// - master clear low forces all divided outputs low, asynchronously
// - after clear, outputs first rise on a rising edge following a falling edge
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps

module cmd_clock_fanout (
  input wire logic pclk, // apb clock, 125 mhz
  input wire logic presetn, // apb reset, asynchronous, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error for unmapped address
  input wire logic primary_clock_in, // first clock pin
  input wire logic secondary_clock_in, // second clock pin
  input wire logic master_clear_n, // master clear pin, active low
  output logic [1:0] first_bank_outputs, // selected clock divided by one or two
  output logic [1:0] second_bank_outputs, // selected clock divided by two
  output logic [1:0] third_bank_outputs, // selected clock divided by four
  output logic [1:0] fourth_bank_outputs // selected clock divided by eight
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pri_s1;
    logic pri_s2;
    logic sec_s1;
    logic sec_s2;
    logic clr_s1;
    logic clr_s2;
    logic sel_prev;
    logic [2:0] ctrl;
    logic frozen;
    logic armed;
    logic [2:0] cnt;
    logic q1;
    logic [31:0] rdata;
  } cmd_state_t;

  cmd_state_t st_ff;
  cmd_state_t nxt_st;

  logic sel_clk;
  logic clk_rise;
  logic clk_fall;
  logic clr_active;
  logic step_ok;
  logic wr_ctrl;
  logic addr_hit;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // selected clock and its edges
  // ----------------------------------------------------------------
  // pick the synchronised clock; a choice change may look like one edge, which is harmless
  // because the chain only ever moves one step per detected edge
  always_comb
  begin
    sel_clk = st_ff.ctrl[cmd_pkg::CTRL_CLK_CHOICE_BIT] ? st_ff.sec_s2 : st_ff.pri_s2;
    clk_rise = sel_clk & ~st_ff.sel_prev;
    clk_fall = ~sel_clk & st_ff.sel_prev;
    clr_active = ~st_ff.clr_s2;
    step_ok = clk_rise & st_ff.armed & ~st_ff.frozen & ~clr_active;
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // zero wait states: the read word is registered in the setup cycle
  always_comb
  begin
    addr_hit = (paddr == cmd_pkg::ADDR_CTRL) || (paddr == cmd_pkg::ADDR_STAT);
    wr_ctrl = psel & penable & pwrite & (paddr == cmd_pkg::ADDR_CTRL);
    rd_mux = 32'h0000_0000;
    if (paddr == cmd_pkg::ADDR_CTRL)
    begin
      rd_mux[cmd_pkg::CTRL_W-1:0] = st_ff.ctrl;
    end
    else if (paddr == cmd_pkg::ADDR_STAT)
    begin
      rd_mux[cmd_pkg::STAT_FROZEN_BIT] = st_ff.frozen;
      rd_mux[cmd_pkg::STAT_ARMED_BIT] = st_ff.armed;
      rd_mux[cmd_pkg::STAT_Q1_BIT] = st_ff.q1;
      rd_mux[cmd_pkg::STAT_CNT_LSB +: cmd_pkg::CNT_W] = st_ff.cnt;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    // two-flop synchronisers for every pin
    nxt_st.pri_s1 = primary_clock_in;
    nxt_st.pri_s2 = st_ff.pri_s1;
    nxt_st.sec_s1 = secondary_clock_in;
    nxt_st.sec_s2 = st_ff.sec_s1;
    nxt_st.clr_s1 = master_clear_n;
    nxt_st.clr_s2 = st_ff.clr_s1;
    nxt_st.sel_prev = sel_clk;
    // software control word
    if (wr_ctrl)
    begin
      nxt_st.ctrl = pwdata[cmd_pkg::CTRL_W-1:0];
    end
    if (psel & ~penable)
    begin
      nxt_st.rdata = rd_mux;
    end
    if (clr_active)
    begin
      // clear holds the whole chain at its start point
      nxt_st.cnt = cmd_pkg::CNT_RESET;
      nxt_st.q1 = 1'b0;
      nxt_st.armed = 1'b0;
      nxt_st.frozen = 1'b0;
    end
    else
    begin
      // freeze flop only moves on a falling edge, so the gated clock is low when it
      // changes and no shortened pulse can reach the chain
      if (clk_fall)
      begin
        nxt_st.frozen = st_ff.ctrl[cmd_pkg::CTRL_FREEZE_BIT];
        nxt_st.armed = 1'b1;
      end
      // count down from zero so that every stage goes high on the first step
      if (step_ok)
      begin
        nxt_st.cnt = st_ff.cnt - cmd_pkg::CNT_STEP;
        nxt_st.q1 = 1'b1;
      end
      else if (clk_fall & st_ff.armed & ~st_ff.frozen)
      begin
        nxt_st.q1 = 1'b0;
      end
      // frozen: nothing above touches cnt or q1, so the count position is kept
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= '{pri_s1: 1'b0, pri_s2: 1'b0, sec_s1: 1'b0, sec_s2: 1'b0,
                 clr_s1: 1'b0, clr_s2: 1'b0, sel_prev: 1'b0,
                 ctrl: cmd_pkg::CTRL_RESET, frozen: 1'b0, armed: 1'b0,
                 cnt: cmd_pkg::CNT_RESET, q1: 1'b0, rdata: 32'h0000_0000};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // the raw clear pin gates the flop outputs so that clear acts at once, without
  // waiting for the synchroniser; the chain itself is cleared on the third pclk edge after the pin falls
  always_comb
  begin
    first_bank_outputs = {cmd_pkg::NUM_COPIES{master_clear_n &
      (st_ff.ctrl[cmd_pkg::CTRL_RATIO_BIT] ? st_ff.cnt[0] : st_ff.q1)}};
    second_bank_outputs = {cmd_pkg::NUM_COPIES{master_clear_n & st_ff.cnt[0]}};
    third_bank_outputs = {cmd_pkg::NUM_COPIES{master_clear_n & st_ff.cnt[1]}};
    fourth_bank_outputs = {cmd_pkg::NUM_COPIES{master_clear_n & st_ff.cnt[2]}};
    prdata = st_ff.rdata;
    pready = 1'b1;
    pslverr = psel & penable & ~addr_hit;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking chk_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_clear_forces_low: assert property (
    !master_clear_n |-> (first_bank_outputs == 2'h0) && (second_bank_outputs == 2'h0)
      && (third_bank_outputs == 2'h0) && (fourth_bank_outputs == 2'h0))
    else $error("outputs not low during master clear");

  chk_copies_match: assert property (
    (first_bank_outputs[0] == first_bank_outputs[1])
      && (second_bank_outputs[0] == second_bank_outputs[1])
      && (third_bank_outputs[0] == third_bank_outputs[1])
      && (fourth_bank_outputs[0] == fourth_bank_outputs[1]))
    else $error("output copies differ");

  chk_step_down: assert property (
    step_ok |=> (st_ff.cnt == $past(st_ff.cnt) - 3'h1) && st_ff.q1)
    else $error("divider chain did not step on a rising edge");

  chk_freeze_hold: assert property (
    st_ff.frozen && !clr_active |=> $stable(st_ff.cnt) && $stable(st_ff.q1))
    else $error("divider moved while frozen");

  chk_freeze_take: assert property (
    clk_fall && !clr_active && st_ff.ctrl[2] |=> st_ff.frozen)
    else $error("freeze not captured on falling edge");

  chk_resume_take: assert property (
    clk_fall && !clr_active && !st_ff.ctrl[2] |=> !st_ff.frozen)
    else $error("freeze not released on falling edge");

  chk_freeze_when_low: assert property (
    $changed(st_ff.frozen) && $past(!clr_active) |-> !$past(sel_clk))
    else $error("freeze state changed while clock high");

  chk_arm_after_fall: assert property (
    !st_ff.armed && clk_rise |=> (st_ff.cnt == $past(st_ff.cnt)) && !st_ff.q1)
    else $error("outputs rose before a falling edge after clear");

  chk_primary_route: assert property (
    !st_ff.ctrl[0] && $rose(st_ff.pri_s2) && st_ff.armed && !st_ff.frozen
      && !clr_active && !st_ff.sel_prev |=> st_ff.q1)
    else $error("primary clock did not drive the chain");

  chk_ratio_pick: assert property (
    master_clear_n && st_ff.ctrl[1] |-> first_bank_outputs[0] == second_bank_outputs[0])
    else $error("first bank not at divide by two");

  // ----------------------------------------------------------------
  // chain and bus checks
  // ----------------------------------------------------------------
  // the divide-by-two stage flips on every accepted rising edge
  chk_div2_toggle: assert property (
    step_ok |=> st_ff.cnt[0] != $past(st_ff.cnt[0]))
    else $error("divide by two stage did not toggle");

  // the divide-by-four stage flips when the stage below it was low
  chk_div4_toggle: assert property (
    step_ok && !st_ff.cnt[0] |=> st_ff.cnt[1] != $past(st_ff.cnt[1]))
    else $error("divide by four stage did not toggle");

  // the divide-by-eight stage flips when both stages below were low
  chk_div8_toggle: assert property (
    step_ok && (st_ff.cnt[1:0] == 2'h0) |=> st_ff.cnt[2] != $past(st_ff.cnt[2]))
    else $error("divide by eight stage did not toggle");

  // the divide-by-one flop follows the falling edge of the selected clock
  chk_div1_fall: assert property (
    clk_fall && st_ff.armed && !st_ff.frozen && !clr_active |=> !st_ff.q1)
    else $error("divide by one flop did not fall");

  // from the all-low point every stage rises on the same edge
  chk_stages_aligned: assert property (
    step_ok && (st_ff.cnt == 3'h0) |=> (st_ff.cnt == 3'h7) && st_ff.q1)
    else $error("common rising edges not aligned");

  // a held clear keeps the whole chain at its start point
  chk_clear_chain: assert property (
    clr_active |=> (st_ff.cnt == 3'h0) && !st_ff.q1 && !st_ff.armed && !st_ff.frozen)
    else $error("chain not cleared during master clear");

  // the chain waits for a falling edge before it may step after clear
  chk_hold_unarmed: assert property (
    !st_ff.armed && !clr_active |=> $stable(st_ff.cnt))
    else $error("chain moved before it was armed");

  // a falling edge outside clear arms the chain
  chk_arm_on_fall: assert property (
    clk_fall && !clr_active |=> st_ff.armed)
    else $error("chain not armed on falling edge");

  // the secondary input drives the chain when the choice is high
  chk_secondary_route: assert property (
    st_ff.ctrl[0] && $rose(st_ff.sec_s2) && st_ff.armed && !st_ff.frozen
      && !clr_active && !st_ff.sel_prev |=> st_ff.q1)
    else $error("secondary clock did not drive the chain");

  // ratio choice low puts the divide-by-one flop on the first bank
  chk_ratio_one: assert property (
    master_clear_n && !st_ff.ctrl[1] |-> first_bank_outputs[0] == st_ff.q1)
    else $error("first bank not at divide by one");

  // the slave never stretches a transfer
  chk_apb_ready: assert property (
    pready)
    else $error("ready dropped");

  // an unmapped access is flagged in its access phase
  chk_err_unmapped: assert property (
    psel && penable && !addr_hit |-> pslverr)
    else $error("unmapped access not flagged");

  // a mapped access never raises the error
  chk_err_mapped: assert property (
    psel && penable && addr_hit |-> !pslverr)
    else $error("mapped access flagged as error");

  // an unmapped read returns zero
  chk_read_zero: assert property (
    psel && !penable && !addr_hit |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  // a write to the control word lands at the end of its access phase
  chk_ctrl_write: assert property (
    psel && penable && pwrite && (paddr == cmd_pkg::ADDR_CTRL)
      |=> st_ff.ctrl == $past(pwdata[cmd_pkg::CTRL_W-1:0]))
    else $error("control write did not land");

  // without a write the control word keeps its value
  chk_ctrl_kept: assert property (
    !(psel && penable && pwrite) |=> $stable(st_ff.ctrl))
    else $error("control word changed without a write");

  cov_freeze_seen: cover property (clk_fall && st_ff.ctrl[2] ##1 st_ff.frozen);
  cov_resume_seen: cover property (st_ff.frozen ##1 !st_ff.frozen);
  cov_full_cycle: cover property (step_ok && st_ff.cnt == 3'h1);
  cov_clear_seen: cover property ($fell(master_clear_n));
  cov_ratio_two: cover property (st_ff.ctrl[1] && step_ok);

endmodule
